// ===== rtl/uapm_mux.sv
// upper address pin mux: six shared pins, select register, boot method capture
// assumes pins are asynchronous to clock_in; the gpio controller and memory interface sit outside
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module uapm_mux
  import uapm_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  input  wire logic [5:0]  ext_mem_address_line_in,
  input  wire logic [5:0]  general_purpose_io_line_in,
  input  wire logic [5:0]  general_purpose_io_oe_in,
  output logic      [5:0]  general_purpose_io_line_out,
  input  wire logic [5:0]  pin_in,
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe_out,
  output logic      [5:0]  boot_method_field_out
);

  // -----------------------------------------------------------------
  // address decode, shared by the register port and its checks
  // -----------------------------------------------------------------
  function automatic logic uapm_hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction

  // -----------------------------------------------------------------
  // pin input synchroniser
  // -----------------------------------------------------------------
  // only the second stage feeds logic; the first may still be settling
  logic [5:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge clock_in) begin
    pin_s1_q <= pin_in;
    pin_s2_q <= pin_s1_q;
  end

  // -----------------------------------------------------------------
  // select register and boot capture
  // -----------------------------------------------------------------
  logic [5:0]       sel_q, sel_d;
  logic [5:0]       boot_q, boot_d;
  logic [3:0]       cnt_q, cnt_d;
  uapm_boot_state_t st_q, st_d;
  logic [15:0]      rdata_q, rdata_d;

  always_comb begin
    sel_d   = sel_q;
    boot_d  = boot_q;
    cnt_d   = cnt_q;
    st_d    = st_q;
    rdata_d = UAPM_RSVD_VALUE;
    if (wr_in && uapm_hit(addr_in, UAPM_PIN_SELECT_OFS)) begin
      sel_d = wdata_in[UAPM_SEL_LSB +: UAPM_SEL_W];
    end
    case (st_q)
      UAPM_WAIT: begin
        if (cnt_q == UAPM_CAPTURE_LAST) begin
          boot_d = pin_s2_q;
          st_d   = UAPM_DONE;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      UAPM_DONE: st_d = UAPM_DONE;
      default:   st_d = UAPM_DONE;
    endcase
    if (rd_in) begin
      if (uapm_hit(addr_in, UAPM_PIN_SELECT_OFS)) begin
        rdata_d[UAPM_SEL_LSB +: UAPM_SEL_W] = sel_q;
      end else if (uapm_hit(addr_in, UAPM_BOOT_MODE_OFS)) begin
        rdata_d[UAPM_BOOT_LSB +: UAPM_SEL_W] = boot_q;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sel_q   <= UAPM_SEL_RESET;
      boot_q  <= UAPM_BOOT_RESET;
      cnt_q   <= 4'h0;
      st_q    <= UAPM_WAIT;
      rdata_q <= UAPM_RSVD_VALUE;
    end else begin
      sel_q   <= sel_d;
      boot_q  <= boot_d;
      cnt_q   <= cnt_d;
      st_q    <= st_d;
      rdata_q <= rdata_d;
    end
  end

  // -----------------------------------------------------------------
  // pin cells; outputs registered so every top output leaves a flip-flop
  // -----------------------------------------------------------------
  logic [5:0] cell_pin, cell_oe;
  logic [5:0] pin_q, oe_q, gpio_in_q;
  logic [5:0] pin_d, oe_d, gpio_in_d;

  for (genvar i = 0; i < 6; i++) begin : g_cell
    uapm_pin_cell u_cell (
      .sel_in      (sel_q[i]),
      .mem_addr_in (ext_mem_address_line_in[i]),
      .gpio_out_in (general_purpose_io_line_in[i]),
      .gpio_oe_in  (general_purpose_io_oe_in[i]),
      .pin_out     (cell_pin[i]),
      .pin_oe_out  (cell_oe[i])
    );
  end

  always_comb begin
    pin_d     = cell_pin;
    oe_d      = cell_oe;
    gpio_in_d = pin_s2_q & sel_q; // gpio sees the pin only while it owns it
  end

  // reset forces gpio function with the driver off, so the pins are inputs
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_q     <= 6'h00;
      oe_q      <= 6'h00;
      gpio_in_q <= 6'h00;
    end else begin
      pin_q     <= pin_d;
      oe_q      <= oe_d;
      gpio_in_q <= gpio_in_d;
    end
  end

  assign pin_out                     = pin_q;
  assign pin_oe_out                  = oe_q;
  assign general_purpose_io_line_out = gpio_in_q;
  assign boot_method_field_out       = boot_q;
  assign rdata_out                   = rdata_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_rst_release;
    $fell(rst_in);
  endsequence
  // capture sits on the tenth edge after release: not one edge earlier, not later
  sequence s_still_counting;
    ##9 st_q == UAPM_WAIT;
  endsequence
  sequence s_capture_done;
    ##10 st_q == UAPM_DONE;
  endsequence
  sequence s_capture_value;
    ##10 boot_q == $past(pin_s2_q);
  endsequence

  // -----------------------------------------------------------------
  // reset state and boot capture
  // -----------------------------------------------------------------
  a_sel_reset_gpio: assert property ($past(rst_in) |-> sel_q == 6'h3f)
    else $error("select not all set after reset");
  a_oe_reset_off: assert property ($past(rst_in) |-> oe_q == 6'h00)
    else $error("pin driven during reset");
  a_boot_capture_time: assert property (s_rst_release |-> s_capture_value)
    else $error("boot method not captured at ten cycles");
  a_capture_not_early: assert property (s_rst_release |-> s_still_counting)
    else $error("boot method captured too early");
  a_capture_state: assert property (s_rst_release |-> s_capture_done)
    else $error("capture state not reached at ten cycles");
  a_boot_held_after: assert property (st_q == UAPM_DONE |=> $stable(boot_q))
    else $error("boot method changed after capture");
  a_boot_zero_before: assert property (st_q == UAPM_WAIT |-> boot_q == UAPM_BOOT_RESET)
    else $error("boot method set before capture");
  a_count_bounded: assert property (cnt_q <= UAPM_CAPTURE_LAST)
    else $error("capture counter out of range");
  a_state_legal: assert property (st_q inside {UAPM_WAIT, UAPM_DONE})
    else $error("capture state illegal");
  a_boot_read_only: assert property (
    st_q == UAPM_DONE && wr_in && uapm_hit(addr_in, UAPM_BOOT_MODE_OFS) |=> $stable(boot_q))
    else $error("boot method written by software");

  // -----------------------------------------------------------------
  // read port: data stands for the one cycle after the strobe, else zero
  // -----------------------------------------------------------------
  // a read of any other address, mapped elsewhere or not, answers zero
  a_rdata_idle: assert property (!rd_in |=> rdata_q == UAPM_RSVD_VALUE)
    else $error("read data not zero without a read");
  a_rdata_select: assert property (
    rd_in && uapm_hit(addr_in, UAPM_PIN_SELECT_OFS) |=> rdata_q == {10'h000, $past(sel_q)})
    else $error("select read back wrong");
  a_rdata_boot: assert property (
    rd_in && uapm_hit(addr_in, UAPM_BOOT_MODE_OFS) |=> rdata_q == {10'h000, $past(boot_q)})
    else $error("boot method read back wrong");
  a_rdata_unmapped: assert property (
    rd_in && !uapm_hit(addr_in, UAPM_PIN_SELECT_OFS) && !uapm_hit(addr_in, UAPM_BOOT_MODE_OFS)
      |=> rdata_q == UAPM_RSVD_VALUE)
    else $error("unmapped read not zero");
  a_write_takes: assert property (
    wr_in && uapm_hit(addr_in, UAPM_PIN_SELECT_OFS) |=> sel_q == $past(wdata_in[5:0]))
    else $error("select write not taken");
  a_sel_hold: assert property (
    !(wr_in && uapm_hit(addr_in, UAPM_PIN_SELECT_OFS)) |=> $stable(sel_q))
    else $error("select changed without a write");

  // -----------------------------------------------------------------
  // per-pin routing, both owners, drive value, enable and input view
  // -----------------------------------------------------------------
  // the extra pin register keeps pads glitch free at the cost of one cycle of latency
  property p_mem_drive(int b);
    !sel_q[b] |=> pin_q[b] == $past(ext_mem_address_line_in[b]) && oe_q[b];
  endproperty
  property p_gpio_drive(int b);
    sel_q[b] |=> pin_q[b] == $past(general_purpose_io_line_in[b])
      && oe_q[b] == $past(general_purpose_io_oe_in[b]);
  endproperty
  property p_gpio_sees(int b);
    sel_q[b] |=> gpio_in_q[b] == $past(pin_s2_q[b]);
  endproperty
  property p_gpio_blind(int b);
    !sel_q[b] |=> !gpio_in_q[b];
  endproperty

  // pin 5: address bit 20 or gpio 26
  a_bit5_route: assert property (
    ##1 !$past(sel_q[5]) |-> pin_q[5] == $past(ext_mem_address_line_in[5]))
    else $error("bit 5 not routed to address");
  a_pin5_mem: assert property (p_mem_drive(5))
    else $error("pin 5 address path wrong");
  a_pin5_gpio: assert property (p_gpio_drive(5))
    else $error("pin 5 gpio path wrong");
  a_pin5_sees: assert property (p_gpio_sees(5))
    else $error("gpio 26 does not see its pin");
  a_pin5_blind: assert property (p_gpio_blind(5))
    else $error("gpio 26 sees a pin it does not own");

  // pin 4: address bit 19 or gpio 25
  a_bit4_route: assert property (
    ##1 $past(sel_q[4]) |-> pin_q[4] == $past(general_purpose_io_line_in[4]))
    else $error("bit 4 not routed to gpio");
  a_pin4_mem: assert property (p_mem_drive(4))
    else $error("pin 4 address path wrong");
  a_pin4_gpio: assert property (p_gpio_drive(4))
    else $error("pin 4 gpio path wrong");
  a_pin4_sees: assert property (p_gpio_sees(4))
    else $error("gpio 25 does not see its pin");
  a_pin4_blind: assert property (p_gpio_blind(4))
    else $error("gpio 25 sees a pin it does not own");

  // pin 3: address bit 18 or gpio 24
  a_bit3_route: assert property (
    ##1 !$past(sel_q[3]) |-> oe_q[3])
    else $error("bit 3 address not driven");
  a_pin3_mem: assert property (p_mem_drive(3))
    else $error("pin 3 address path wrong");
  a_pin3_gpio: assert property (p_gpio_drive(3))
    else $error("pin 3 gpio path wrong");
  a_pin3_sees: assert property (p_gpio_sees(3))
    else $error("gpio 24 does not see its pin");
  a_pin3_blind: assert property (p_gpio_blind(3))
    else $error("gpio 24 sees a pin it does not own");

  // pin 2: address bit 17 or gpio 23
  a_bit2_route: assert property (
    ##1 $past(sel_q[2]) |-> oe_q[2] == $past(general_purpose_io_oe_in[2]))
    else $error("bit 2 gpio enable wrong");
  a_pin2_mem: assert property (p_mem_drive(2))
    else $error("pin 2 address path wrong");
  a_pin2_gpio: assert property (p_gpio_drive(2))
    else $error("pin 2 gpio path wrong");
  a_pin2_sees: assert property (p_gpio_sees(2))
    else $error("gpio 23 does not see its pin");
  a_pin2_blind: assert property (p_gpio_blind(2))
    else $error("gpio 23 sees a pin it does not own");

  // pin 1: address bit 16 or gpio 22
  a_bit1_route: assert property (
    ##1 !$past(sel_q[1]) |-> pin_q[1] == $past(ext_mem_address_line_in[1]))
    else $error("bit 1 not routed to address");
  a_pin1_mem: assert property (p_mem_drive(1))
    else $error("pin 1 address path wrong");
  a_pin1_gpio: assert property (p_gpio_drive(1))
    else $error("pin 1 gpio path wrong");
  a_pin1_sees: assert property (p_gpio_sees(1))
    else $error("gpio 22 does not see its pin");
  a_pin1_blind: assert property (p_gpio_blind(1))
    else $error("gpio 22 sees a pin it does not own");

  // pin 0: address bit 15 or gpio 21
  a_bit0_route: assert property (
    ##1 $past(sel_q[0]) |-> pin_q[0] == $past(general_purpose_io_line_in[0]))
    else $error("bit 0 not routed to gpio");
  a_pin0_mem: assert property (p_mem_drive(0))
    else $error("pin 0 address path wrong");
  a_pin0_gpio: assert property (p_gpio_drive(0))
    else $error("pin 0 gpio path wrong");
  a_pin0_sees: assert property (p_gpio_sees(0))
    else $error("gpio 21 does not see its pin");
  a_pin0_blind: assert property (p_gpio_blind(0))
    else $error("gpio 21 sees a pin it does not own");

endmodule

// ===== rtl/uapm_pkg.sv
// constants for the upper address pin mux: register map, field layout, reset values, timing
// assumes a single 200 MHz clock domain and a plain word-wide register port
//
// What this block does
// - selection bit 5 clear routes its pin to memory address bit 20, set routes it to gpio 26.
// - selection bit 4 clear routes its pin to memory address bit 19, set routes it to gpio 25.
// - selection bit 3 clear routes its pin to memory address bit 18, set routes it to gpio 24.
// - selection bit 2 clear routes its pin to memory address bit 17, set routes it to gpio 23.
// - selection bit 1 clear routes its pin to memory address bit 16, set routes it to gpio 22.
// - selection bit 0 clear routes its pin to memory address bit 15, set routes it to gpio 21.
// - reset sets all six selection bits and leaves the gpio lines as inputs.
// - ten cycles after reset release the six pin levels are captured as the boot method.
// - the captured levels sit in a six-bit boot method field of the boot mode register.
package uapm_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [15:0] UAPM_PIN_SELECT_OFS = 16'h1c00;
  localparam logic [15:0] UAPM_BOOT_MODE_OFS  = 16'h1c34;

  // -----------------------------------------------------------------
  // fields and reset values
  // -----------------------------------------------------------------
  localparam int          UAPM_SEL_LSB        = 0;
  localparam int          UAPM_SEL_W          = 6;
  localparam int          UAPM_BOOT_LSB       = 0;
  localparam logic [5:0]  UAPM_SEL_RESET      = 6'h3f;
  localparam logic [5:0]  UAPM_BOOT_RESET     = 6'h00;
  localparam logic [15:0] UAPM_RSVD_VALUE     = 16'h0000;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int          UAPM_CAPTURE_CYCLES = 10;
  localparam logic [3:0]  UAPM_CAPTURE_LAST   = 4'(UAPM_CAPTURE_CYCLES - 1);

  typedef enum logic [1:0] {
    UAPM_WAIT = 2'b00,
    UAPM_DONE = 2'b01
  } uapm_boot_state_t;

endpackage

// ===== rtl/uapm_pin_cell.sv
// one shared pin: chooses memory address or gpio drive by a select bit
// assumes the select bit comes from a flip-flop on the same clock
`timescale 1ns/10ps
module uapm_pin_cell (
  input  wire logic sel_in,
  input  wire logic mem_addr_in,
  input  wire logic gpio_out_in,
  input  wire logic gpio_oe_in,
  output logic      pin_out,
  output logic      pin_oe_out
);
  // memory address drives the pin always when selected; gpio drives only with its enable
  always_comb begin
    pin_out    = sel_in ? gpio_out_in : mem_addr_in;
    pin_oe_out = sel_in ? gpio_oe_in  : 1'b1;
  end
endmodule

// ===== tb/uapm_far_side.sv
// far side model: memory address bus, gpio controller and pad straps
// assumes the bench changes req_in just after rising edges
`timescale 1ns/10ps
module uapm_far_side (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic [5:0] req_in,
  input  wire logic [5:0] strap_in,
  input  wire logic [5:0] pin_in,
  input  wire logic [5:0] pin_oe_in,
  output logic      [5:0] mem_out,
  output logic      [5:0] gpio_out,
  output logic      [5:0] gpio_oe_out,
  output logic      [5:0] pad_out
);
  // gpio enables stay low in reset so the straps are not fought
  always_ff @(posedge clock_in) begin
    mem_out     <= req_in;
    gpio_out    <= ~req_in;
    gpio_oe_out <= rst_in ? 6'h00 : req_in ^ 6'h2a;
  end
  // released pads fall to their strap pulls
  assign pad_out = (pin_oe_in & pin_in) | (~pin_oe_in & strap_in);
endmodule

// ===== tb/test_upper_address_pin_mux.sv
// self-checking bench for the upper address pin mux
// assumes the far side model drives the memory, gpio and pad inputs
`timescale 1ns/10ps
module test_upper_address_pin_mux;
  import uapm_pkg::*;
  logic        clock_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
  logic [15:0] addr_in = 0, wdata_in = 0, rdata_out, d;
  logic [5:0]  req = 6'h2a, strap, mem, gpo, goe, pad, pin_out, pin_oe_out, gpi, boot, s, ep, eo;
  integer      seed = 32'h47de67a6;
  int          err_count = 0, tests_run = 0;
  always #2.5 clock_in = ~clock_in;
  uapm_far_side far (.clock_in, .rst_in, .req_in(req), .strap_in(strap), .pin_in(pin_out),
    .pin_oe_in(pin_oe_out), .mem_out(mem), .gpio_out(gpo), .gpio_oe_out(goe), .pad_out(pad));
  uapm_mux dut (.clock_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .ext_mem_address_line_in(mem), .general_purpose_io_line_in(gpo),
    .general_purpose_io_oe_in(goe), .general_purpose_io_line_out(gpi), .pin_in(pad),
    .pin_out, .pin_oe_out, .boot_method_field_out(boot));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] v);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    strap <= 6'($random(seed));
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(UAPM_PIN_SELECT_OFS);
    chk("sel reset", 16'(UAPM_SEL_RESET), d);
    chk("oe reset", 16'h0000, 16'(pin_oe_out));
    repeat (12) @(posedge clock_in);
    #1 chk("boot", 16'(strap), 16'(boot));
    wr(UAPM_BOOT_MODE_OFS, 16'hffff);
    rd(UAPM_BOOT_MODE_OFS);
    chk("boot reg", 16'(strap), d);
    rd(16'h1c35);
    chk("unmapped", 16'h0000, d);
    for (int i = 0; i < 60; i++) begin
      s = (i < 2) ? {6{i[0]}} : 6'($random(seed));
      wr(UAPM_PIN_SELECT_OFS, {10'h3ff, s});
      req <= 6'($random(seed));
      repeat (6) @(posedge clock_in);
      // gpio sees the pad only where it owns the pin
      ep = s ^ req;
      eo = (s & (req ^ 6'h2a)) | ~s;
      #1 chk("pin", 16'(ep), 16'(pin_out));
      chk("pin oe", 16'(eo), 16'(pin_oe_out));
      chk("gpio in", 16'(s & ((eo & ep) | (~eo & strap))), 16'(gpi));
      rd(UAPM_PIN_SELECT_OFS);
      chk("sel", {10'h000, s}, d);
    end
    // second reset mid-run: pins fall back to gpio inputs and the straps are read again
    @(posedge clock_in);
    req <= 6'h2a;
    strap <= 6'($random(seed));
    rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(UAPM_PIN_SELECT_OFS);
    chk("sel reset again", 16'(UAPM_SEL_RESET), d);
    chk("oe reset again", 16'h0000, 16'(pin_oe_out));
    repeat (12) @(posedge clock_in);
    #1 chk("boot again", 16'(strap), 16'(boot));
    summarize();
  end
  initial begin
    #100000;
    err_count++;
    summarize();
  end
endmodule
